// >>> verilog/pbe_defs.svh
// constants of the postfix boolean equation evaluator
`ifndef PBE_DEFS_SVH
`define PBE_DEFS_SVH

// ==========================================================================
// register map (byte addresses)
`define PBE_OFF_VIN        12'h000
`define PBE_OFF_RES        12'h004
`define PBE_OFF_ERR        12'h008
`define PBE_OFF_CTRL       12'h00c
`define PBE_OFF_PARAM      12'h400
`define PBE_CTRL_RUN       0
`define PBE_CTRL_RST       1'b1

// ==========================================================================
// equation layout
`define PBE_N_EQ           14
`define PBE_N_RELAY        8
`define PBE_N_VOUT         5
`define PBE_EQ_TRACE       8
`define PBE_EQ_VOUT_LO     9
`define PBE_EQ_LAST        4'd13
`define PBE_SLOW_MASK      14'h00e0
`define PBE_LONG_LEN       20
`define PBE_SHORT_LEN      10
`define PBE_MEM_WORDS      280
`define PBE_MAX_IN_LONG    5'd19
`define PBE_MAX_IN_SHORT   5'd9
`define PBE_MIN_IN         5'd2
`define PBE_NOT_IN         5'd1

// ==========================================================================
// input terms
`define PBE_N_ELEM         32
`define PBE_N_LOGIC        16
`define PBE_N_VIN          16
`define PBE_N_TIMER        10
`define PBE_N_TERM         119

// ==========================================================================
// timing
`define PBE_SLOW_MS        100
`define PBE_CLK_KHZ        10000

`endif

// >>> verilog/pbe_pkg.sv
// types shared by the equation evaluator files
package pbe_pkg;

   // =======================================================================
   // parameter opcodes
   typedef enum logic [3:0] {
      PBE_OP_END  = 4'h0,
      PBE_OP_TERM = 4'h1,
      PBE_OP_NOT  = 4'h2,
      PBE_OP_OR   = 4'h3,
      PBE_OP_AND  = 4'h4,
      PBE_OP_NOR  = 4'h5,
      PBE_OP_NAND = 4'h6,
      PBE_OP_XOR  = 4'h7
   } pbe_op_t;

   // op kept as raw bits so that illegal codes can be seen and flagged
   typedef struct packed {
      logic [3:0] op;
      logic [3:0] rsv;
      logic [7:0] arg;
   } pbe_param_t;

   // =======================================================================
   // apb carriers
   typedef struct packed {
      logic [11:0] paddr;
      logic        pwrite;
      logic [31:0] pwdata;
      logic        psel;
      logic        penable;
   } pbe_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } pbe_apb_rsp_t;

   // =======================================================================
   // sequencer states
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_LOAD = 4'b0010,
      S_STEP = 4'b0100,
      S_DONE = 4'b1000
   } pbe_state_t;

endpackage : pbe_pkg

// >>> verilog/pbe_stack.sv
// operand stack that executes one postfix parameter per cycle
`timescale 1ns/1ns
`default_nettype none
`include "pbe_defs.svh"

module pbe_stack
   import pbe_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_clr,
   input  wire logic       i_valid,
   input  wire pbe_param_t i_param,
   input  wire logic       i_term_val,
   input  wire logic       i_term_ok,
   input  wire logic       i_long,
   output logic [4:0]      o_depth,
   output logic            o_top,
   output logic            o_err
);

   logic [`PBE_LONG_LEN-1:0] stk_q;
   logic [`PBE_LONG_LEN-1:0] stk_d;
   logic [`PBE_LONG_LEN-1:0] mask;
   logic [4:0]               depth_q;
   logic                     err_q;
   logic                     gate_val;

   // =======================================================================
   // decode
   wire       is_term  = i_param.op == PBE_OP_TERM;
   wire       is_not   = i_param.op == PBE_OP_NOT;
   wire       is_multi = i_param.op >= PBE_OP_OR && i_param.op <= PBE_OP_XOR;
   wire [4:0] n_in     = i_param.arg[4:0];
   wire [4:0] max_in   = i_long ? `PBE_MAX_IN_LONG : `PBE_MAX_IN_SHORT;
   wire [4:0] cnt      = is_not ? `PBE_NOT_IN : n_in;
   wire [4:0] lo       = depth_q - cnt;
   wire       bad      = !(is_term || is_not || is_multi)
                       || (is_term && !i_term_ok)
                       || (is_not && n_in != `PBE_NOT_IN)
                       || (is_multi && (n_in < `PBE_MIN_IN
                                        || n_in > max_in))
                       || (!is_term && cnt > depth_q);
   wire       wr       = i_valid && !bad && !err_q;

   // =======================================================================
   // gate over the top cnt entries
   genvar gi;
   generate
      for (gi = 0; gi < `PBE_LONG_LEN; gi++)
      begin : g_bit
         assign mask[gi]  = (5'(gi) >= lo) && (5'(gi) < depth_q);
         assign stk_d[gi] = (wr && 5'(gi) == (is_term ? depth_q : lo))
                          ? (is_term ? i_term_val : gate_val) : stk_q[gi];
      end
   endgenerate

   wire sel_any = |(stk_q & mask);
   wire sel_all = &(stk_q | ~mask);
   wire sel_odd = ^(stk_q & mask);
   always_comb
   begin
      case (i_param.op)
         PBE_OP_NOT:  gate_val = ~sel_any;
         PBE_OP_OR:   gate_val = sel_any;
         PBE_OP_AND:  gate_val = sel_all;
         PBE_OP_NOR:  gate_val = ~sel_any;
         PBE_OP_NAND: gate_val = ~sel_all;
         PBE_OP_XOR:  gate_val = sel_odd;
         default:     gate_val = 1'b0;
      endcase
   end

   // =======================================================================
   // state; a gate leaves one result where its operands began
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n || i_clr)
      begin
         stk_q   <= '0;
         depth_q <= '0;
         err_q   <= 1'b0;
      end
      else
      begin
         stk_q <= stk_d;
         if (wr)
            depth_q <= is_term ? depth_q + 5'd1 : lo + 5'd1;
         if (i_valid && bad)
            err_q <= 1'b1;
      end
   end

   assign o_depth = depth_q;
   assign o_top   = (depth_q == 5'd0) ? 1'b0 : stk_q[5'(depth_q - 5'd1)];
   assign o_err   = err_q;

   // =======================================================================
   // checks
   push_depth_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (wr && is_term && !i_clr) |=> depth_q == $past(depth_q) + 5'd1)
      else $error("push did not grow stack");
   not_arity_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_valid && is_not && n_in != `PBE_NOT_IN && !i_clr) |=> err_q)
      else $error("bad not arity not flagged");
   gate_pop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (wr && !is_term && !i_clr) |=> depth_q == $past(lo) + 5'd1)
      else $error("gate left wrong depth");
   or_value_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (wr && i_param.op == PBE_OP_OR && !i_clr) |=> o_top == $past(sel_any))
      else $error("or result wrong");

endmodule : pbe_stack
`default_nettype wire

// >>> verilog/pbe_top.sv
// postfix boolean equation evaluator with apb setup access
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "pbe_defs.svh"

// Overview of operation
// - every equation evaluates to one bit: 1 operates, 0 does not.
// - relay equations hold up to 20 parameters each.
// - five virtual output equations of 10 parameters, usable as terms.
// - capture trigger has its own 10 parameter equation.
// - fast group each half cycle; relays 6-8, self-test every 100 ms.
// - a parameter is an input term or a gate, nothing else.
// - pickup term is threshold exceeded; operate term is after its delay.
// - logic and virtual input terms read 1 while asserted.
// - relay and virtual output terms read their equation result.
// - timer terms read 1 once their start held for the delay.
// - not, or, and, nor, nand, xor give their usual boolean results.
// - not takes one input; others take 2-19 or 2-9 inputs.
// - postfix order: a gate consumes operands placed before it.
// - each gate yields one result usable by a later gate.
// - a term may repeat; each occurrence is evaluated on its own.
// - any relay or virtual output result may feed any equation, including its own.
// - an unresolvable equation raises a self-test error, cleared by the first slow pass that finds no error.
module pbe_top
   import pbe_pkg::*;
#(
   parameter int P_SLOW_TICKS = `PBE_SLOW_MS * `PBE_CLK_KHZ
)
(
   input  wire logic                    i_clk,
   input  wire logic                    i_rst_n,
   input  wire pbe_apb_req_t            i_apb,
   output pbe_apb_rsp_t                 o_apb,
   input  wire logic                    i_half_cycle,
   input  wire logic [`PBE_N_ELEM-1:0]  i_elem_pkp,
   input  wire logic [`PBE_N_ELEM-1:0]  i_elem_op,
   input  wire logic [`PBE_N_LOGIC-1:0] i_logic_in,
   input  wire logic [`PBE_N_TIMER-1:0] i_timer_done,
   output logic [`PBE_N_RELAY-1:0]      o_relay,
   output logic                         o_self_test_relay,
   output logic                         o_trace_trig,
   output logic [`PBE_N_VOUT-1:0]       o_virt_out,
   output logic                         o_eqn_err
);

   // =======================================================================
   // storage
   logic [15:0]              mem_q [`PBE_MEM_WORDS];
   logic [`PBE_N_VIN-1:0]    vin_q;
   logic                     run_q;
   logic [`PBE_N_LOGIC-1:0]  lin_s1_q;
   logic [`PBE_N_LOGIC-1:0]  lin_s2_q;
   logic [`PBE_N_EQ-1:0]     res_q;
   logic [`PBE_N_EQ-1:0]     res_d;
   logic [`PBE_N_EQ-1:0]     err_q;
   logic [`PBE_N_EQ-1:0]     err_d;
   logic [`PBE_N_EQ-1:0]     work_res_q;
   logic [`PBE_N_EQ-1:0]     work_err_q;
   logic                     st_q;
   logic [31:0]              prdata_q;
   logic                     pslverr_q;
   pbe_state_t               state_q;
   logic [3:0]               eq_q;
   logic [4:0]               idx_q;
   logic                     grp_fast_q;
   logic                     pend_fast_q;
   logic                     pend_slow_q;
   logic [23:0]              slow_cnt_q;
   logic [4:0]               stk_depth;
   logic                     stk_top;
   logic                     stk_err;

   // =======================================================================
   // apb decode
   wire        apb_setup  = i_apb.psel && !i_apb.penable;
   wire        apb_access = i_apb.psel && i_apb.penable;
   wire [11:0] off        = i_apb.paddr;
   wire [11:0] p_rel      = off - `PBE_OFF_PARAM;
   wire [8:0]  p_idx      = p_rel[10:2];
   wire        hit_param  = off >= `PBE_OFF_PARAM
                         && p_rel[11] == 1'b0
                         && p_idx < 9'(`PBE_MEM_WORDS);
   wire        aligned    = off[1:0] == 2'b00;
   wire        hit_vin    = off == `PBE_OFF_VIN;
   wire        hit_res    = off == `PBE_OFF_RES;
   wire        hit_err    = off == `PBE_OFF_ERR;
   wire        hit_ctrl   = off == `PBE_OFF_CTRL;
   wire        mapped     = aligned && (hit_param || hit_vin || hit_res
                                        || hit_err || hit_ctrl);
   wire        wr_en      = apb_access && i_apb.pwrite && mapped;
   wire [31:0] rd_mux     = hit_vin   ? 32'(vin_q)
                          : hit_res   ? 32'(res_q)
                          : hit_err   ? 32'(err_q)
                          : hit_ctrl  ? 32'(run_q)
                          : hit_param ? 32'(mem_q[p_idx])
                          : 32'h0000_0000;

   // zero wait states: data is captured in the setup cycle
   assign o_apb.pready  = 1'b1;
   assign o_apb.prdata  = prdata_q;
   assign o_apb.pslverr = pslverr_q;

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end
      else if (apb_setup)
      begin
         prdata_q  <= i_apb.pwrite ? 32'h0000_0000 : rd_mux;
         pslverr_q <= !mapped;
      end
   end

   // setup may be rewritten mid pass; the pass simply sees the new entry
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         for (int k = 0; k < `PBE_MEM_WORDS; k++)
            mem_q[k] <= 16'h0000;
         vin_q <= '0;
         run_q <= `PBE_CTRL_RST;
      end
      else if (wr_en)
      begin
         if (hit_param)
            mem_q[p_idx] <= i_apb.pwdata[15:0];
         if (hit_vin)
            vin_q <= i_apb.pwdata[`PBE_N_VIN-1:0];
         if (hit_ctrl)
            run_q <= i_apb.pwdata[`PBE_CTRL_RUN];
      end
   end

   // =======================================================================
   // input terms
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         lin_s1_q <= '0;
         lin_s2_q <= '0;
      end
      else
      begin
         lin_s1_q <= i_logic_in;
         lin_s2_q <= lin_s1_q;
      end
   end

   // element and timer levels come already qualified by their own logic
   wire [`PBE_N_TERM-1:0] terms = {
      i_timer_done,
      res_q[`PBE_N_EQ-1:`PBE_EQ_VOUT_LO],
      res_q[`PBE_N_RELAY-1:0],
      vin_q,
      lin_s2_q,
      i_elem_op,
      i_elem_pkp
   };

   // =======================================================================
   // pass scheduling
   wire slow_tick = slow_cnt_q == 24'(P_SLOW_TICKS - 1);
   wire commit    = state_q == S_DONE;
   wire start     = state_q == S_IDLE && run_q
                 && (pend_fast_q || pend_slow_q);
   wire [`PBE_N_EQ-1:0] slow_set = `PBE_SLOW_MASK;
   wire is_slow   = slow_set[eq_q];
   wire in_grp    = grp_fast_q ? !is_slow : is_slow;
   wire [`PBE_N_EQ-1:0] grp_mask = grp_fast_q ? ~`PBE_SLOW_MASK
                                              : `PBE_SLOW_MASK;

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n || slow_tick)
         slow_cnt_q <= '0;
      else
         slow_cnt_q <= slow_cnt_q + 24'd1;
   end

   // cleared as its pass starts, so a trigger mid pass stays pending
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         pend_fast_q <= 1'b0;
         pend_slow_q <= 1'b0;
      end
      else
      begin
         pend_fast_q <= (pend_fast_q && !start)
                     || i_half_cycle;
         pend_slow_q <= (pend_slow_q && !(start && !pend_fast_q))
                     || slow_tick;
      end
   end

   // =======================================================================
   // equation walk
   wire              eq_long  = eq_q < 4'(`PBE_N_RELAY);
   wire [4:0]        eq_len   = eq_long ? 5'(`PBE_LONG_LEN)
                                        : 5'(`PBE_SHORT_LEN);
   wire [8:0]        mem_addr = 9'(eq_q) * 9'(`PBE_LONG_LEN) + 9'(idx_q);
   wire pbe_param_t  cur      = pbe_param_t'(mem_q[mem_addr]);
   wire              stop     = cur.op == PBE_OP_END
                             || idx_q == eq_len;
   wire              stk_go   = state_q == S_STEP && !stop;
   wire              term_ok  = cur.arg < 8'(`PBE_N_TERM);
   wire              fin_err  = stk_err
                             || (stk_depth != 5'd1 && idx_q != 5'd0);
   wire              fin_res  = !fin_err && stk_depth == 5'd1 && stk_top;

   pbe_stack u_stack (
      .i_clk      (i_clk),
      .i_rst_n    (i_rst_n),
      .i_clr      (state_q == S_LOAD),
      .i_valid    (stk_go),
      .i_param    (cur),
      .i_term_val (terms[cur.arg[6:0]]),
      .i_term_ok  (term_ok),
      .i_long     (eq_long),
      .o_depth    (stk_depth),
      .o_top      (stk_top),
      .o_err      (stk_err)
   );

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         state_q    <= S_IDLE;
         eq_q       <= 4'd0;
         idx_q      <= 5'd0;
         grp_fast_q <= 1'b1;
         work_res_q <= '0;
         work_err_q <= '0;
      end
      else
      begin
         case (state_q)
            S_IDLE:
               if (start)
               begin
                  grp_fast_q <= pend_fast_q;
                  eq_q       <= 4'd0;
                  state_q    <= S_LOAD;
               end
            S_LOAD:
               if (in_grp)
               begin
                  idx_q   <= 5'd0;
                  state_q <= S_STEP;
               end
               else if (eq_q == `PBE_EQ_LAST)
                  state_q <= S_DONE;
               else
                  eq_q <= eq_q + 4'd1;
            S_STEP:
               if (stop)
               begin
                  work_res_q[eq_q] <= fin_res;
                  work_err_q[eq_q] <= fin_err;
                  if (eq_q == `PBE_EQ_LAST)
                     state_q <= S_DONE;
                  else
                  begin
                     eq_q    <= eq_q + 4'd1;
                     state_q <= S_LOAD;
                  end
               end
               else
                  idx_q <= idx_q + 5'd1;
            S_DONE:
               state_q <= S_IDLE;
            default:
               state_q <= S_IDLE;
         endcase
      end
   end

   // =======================================================================
   // results change only at the end of a pass
   assign res_d = (res_q & ~grp_mask) | (work_res_q & grp_mask);
   assign err_d = (err_q & ~grp_mask) | (work_err_q & grp_mask);

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         res_q <= '0;
         err_q <= '0;
         st_q  <= 1'b0;
      end
      else if (commit)
      begin
         res_q <= res_d;
         err_q <= err_d;
         if (!grp_fast_q)
            st_q <= |err_d;
      end
   end

   assign o_relay           = res_q[`PBE_N_RELAY-1:0];
   assign o_trace_trig      = res_q[`PBE_EQ_TRACE];
   assign o_virt_out        = res_q[`PBE_N_EQ-1:`PBE_EQ_VOUT_LO];
   assign o_self_test_relay = st_q;
   assign o_eqn_err         = |err_q;

   // =======================================================================
   // checks
   latch_pass_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (res_q != $past(res_q)) |-> $past(state_q) == S_DONE)
      else $error("result moved outside commit");
   fast_pend_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_half_cycle |=> pend_fast_q)
      else $error("half cycle trigger lost");
   slow_pend_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      slow_tick |=> pend_slow_q ##0 slow_cnt_q == 24'd0)
      else $error("slow tick lost");
   end_stop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (state_q == S_STEP && stop && eq_q != `PBE_EQ_LAST)
      |=> state_q == S_LOAD && eq_q == $past(eq_q) + 4'd1)
      else $error("walk did not stop at end");
   self_test_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (commit && !grp_fast_q) |=> o_self_test_relay == |err_q)
      else $error("self-test relay disagrees with errors");
   one_value_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (state_q == S_STEP && stop && stk_depth == 5'd1 && !stk_err)
      |=> work_res_q[$past(eq_q)] == $past(stk_top))
      else $error("stack value not taken as result");
   slow_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (commit && grp_fast_q) |=> o_relay[7:5] == $past(o_relay[7:5]))
      else $error("fast pass touched slow relays");

   fast_pass_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
      commit && grp_fast_q);
   slow_pass_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
      commit && !grp_fast_q);
   eqn_err_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
      state_q == S_STEP && stop && fin_err);
   relay_on_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
      $rose(o_relay[0]));

endmodule : pbe_top
`default_nettype wire

// >>> verification/pbe_field.sv
// model of the field side: elements, logic inputs, timers, line timing
`timescale 1ns/1ns
`default_nettype none

module pbe_field
#(
   parameter int P_HALF = 500,
   parameter int P_DLY  = 4
)
(
   input  wire logic       i_clk,
   input  wire logic [3:0] i_scene,
   output var  logic       o_half_cycle,
   output logic [31:0]     o_pkp,
   output logic [31:0]     o_op,
   output logic [15:0]     o_logic,
   output logic [9:0]      o_timer
);
   // ======================================================================
   // line timing and delayed levels
   int cnt_q  = 0;
   int hold_q = 0;
   int run_q  = 0;
   initial o_half_cycle = 1'b0;
   always @(posedge i_clk)
   begin
      cnt_q        <= (cnt_q == P_HALF - 1) ? 0 : cnt_q + 1;
      o_half_cycle <= (cnt_q == P_HALF - 1);
      hold_q       <= i_scene[0] ? hold_q + 1 : 0;
      run_q        <= i_scene[3] ? run_q + 1 : 0;
   end
   // operate and timer levels only after the start has held
   assign o_pkp   = {31'h0, i_scene[0]};
   assign o_op    = {31'h0, hold_q >= P_DLY};
   assign o_logic = {14'h0, i_scene[2:1]};
   assign o_timer = {9'h0, run_q >= P_DLY};
endmodule : pbe_field
`default_nettype wire

// >>> verification/test_postfix_boolean_equation_evaluator.sv
// self-checking bench for the postfix equation evaluator
`timescale 1ns/1ns
`default_nettype none
`include "pbe_defs.svh"

module test_postfix_boolean_equation_evaluator
   import pbe_pkg::*;
;
   logic         clk   = 1'b0;
   logic         rst_n = 1'b0;
   pbe_apb_req_t req   = '0;
   pbe_apb_rsp_t rsp;
   logic [3:0]   scene = 4'h0;
   logic         half;
   logic [31:0]  pkp, op, rd;
   logic [15:0]  lgc;
   logic [9:0]   tmr;
   logic [7:0]   relay;
   logic [4:0]   vout;
   logic         st, trig, err, se;
   int           failures    = 0;
   int           comparisons = 0;

   pbe_top #(.P_SLOW_TICKS(200)) pbe_top_i (.i_clk(clk), .i_rst_n(rst_n),
      .i_apb(req), .o_apb(rsp), .i_half_cycle(half), .i_elem_pkp(pkp),
      .i_elem_op(op), .i_logic_in(lgc), .i_timer_done(tmr),
      .o_relay(relay), .o_self_test_relay(st), .o_trace_trig(trig),
      .o_virt_out(vout), .o_eqn_err(err));
   pbe_field pbe_field_i (.i_clk(clk), .i_scene(scene),
      .o_half_cycle(half), .o_pkp(pkp), .o_op(op), .o_logic(lgc),
      .o_timer(tmr));

   // ======================================================================
   // tasks
   task automatic finish_test;
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e)
      begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk

   // request held until pready seen high with penable
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      req.psel    <= 1'b1;
      req.penable <= 1'b0;
      req.paddr   <= a;
      req.pwrite  <= w;
      req.pwdata  <= d;
      @(posedge clk);
      req.penable <= 1'b1;
      do @(posedge clk); while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      se = rsp.pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb

   task automatic eq(input int e, input int k, input logic [3:0] o,
                     input logic [7:0] g);
      apb(1'b1, `PBE_OFF_PARAM + 12'(4 * (e * 20 + k)), {16'h0, o, 4'h0, g});
   endtask : eq

   // ======================================================================
   // clock, watchdog, tests
   initial forever #50 clk = ~clk;

   initial
   begin
      repeat (10000) @(posedge clk);
      failures++;
      finish_test();
   end

   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, `PBE_OFF_CTRL, 32'h0);
      chk(rd, 32'h1);
      chk(32'(relay), 32'h0);
      // pkp0=1, vin1=1, vin0=0 through each multi-input gate
      for (int g = 0; g < 5; g++)
      begin
         eq(g, 0, PBE_OP_TERM, 8'h51);
         eq(g, 1, PBE_OP_TERM, 8'h50);
         eq(g, 2, PBE_OP_TERM, 8'h00);
         eq(g, 3, 4'(3 + g), 8'h03);
      end
      eq(5, 0, PBE_OP_TERM, 8'h6d);
      eq(8, 0, PBE_OP_TERM, 8'h00);
      eq(8, 1, PBE_OP_TERM, 8'h00);
      eq(8, 2, PBE_OP_OR, 8'h0a);
      eq(9, 0, PBE_OP_TERM, 8'h40);
      eq(9, 1, PBE_OP_NOT, 8'h01);
      eq(10, 0, PBE_OP_TERM, 8'h68);
      eq(10, 1, PBE_OP_TERM, 8'h20);
      eq(10, 2, PBE_OP_AND, 8'h02);
      eq(11, 0, PBE_OP_TERM, 8'h51);
      eq(11, 1, PBE_OP_TERM, 8'h51);
      eq(11, 2, PBE_OP_AND, 8'h02);
      apb(1'b1, `PBE_OFF_VIN, 32'h2);
      scene <= 4'h9;
      repeat (1600) @(posedge clk);
      chk(32'(relay), 32'h29);
      chk(32'(vout), 32'h7);
      chk(32'(trig), 32'h0);
      chk(32'(err), 32'h1);
      chk(32'(st), 32'h1);
      apb(1'b1, `PBE_OFF_RES, 32'h0);
      apb(1'b0, `PBE_OFF_RES, 32'h0);
      chk(rd, 32'he29);
      apb(1'b0, `PBE_OFF_ERR, 32'h0);
      chk(rd, 32'h100);
      apb(1'b0, 12'h010, 32'h0);
      chk({31'h0, se}, 32'h1);
      chk(rd, 32'h0);
      $display("test gates and terms done");
      repeat (600) @(posedge clk);
      chk(32'(err), 32'h1);
      eq(8, 2, PBE_OP_OR, 8'h02);
      eq(8, 3, PBE_OP_END, 8'h00);
      scene <= 4'h1;
      repeat (1600) @(posedge clk);
      chk(32'(err), 32'h0);
      chk(32'(st), 32'h0);
      chk(32'(trig), 32'h1);
      apb(1'b0, `PBE_OFF_RES, 32'h0);
      chk(rd, 32'hf09);
      $display("test error recovery done");
      eq(12, 0, 4'h8, 8'h00);
      eq(13, 0, PBE_OP_TERM, 8'h51);
      eq(13, 1, PBE_OP_AND, 8'h02);
      repeat (600) @(posedge clk);
      apb(1'b0, `PBE_OFF_ERR, 32'h0);
      chk(rd, 32'h3000);
      chk(32'(vout), 32'h7);
      chk(32'(err), 32'h1);
      $display("test malformed equations done");
      finish_test();
   end
endmodule : test_postfix_boolean_equation_evaluator
`default_nettype wire
